/* hdl/ccms_pkg.sv */
// Package for the core clock mode selector: mode codes, factors, timing.
// Assumes a single 50 MHz reference clock that samples every other signal.
package ccms_pkg;

	// ------------------------------------------------------------------
	// Mode codes on the three configuration pins
	// ------------------------------------------------------------------
	localparam logic [2:0] CCMS_CODE_X4 = 3'h7;
	localparam logic [2:0] CCMS_CODE_X3 = 3'h6;
	localparam logic [2:0] CCMS_CODE_X2 = 3'h5;
	localparam logic [2:0] CCMS_CODE_X5 = 3'h4;
	localparam logic [2:0] CCMS_CODE_DIRECT = 3'h3;
	localparam logic [2:0] CCMS_CODE_X1P5 = 3'h2;
	localparam logic [2:0] CCMS_CODE_PRESCALE = 3'h1;
	localparam logic [2:0] CCMS_CODE_X2P5 = 3'h0;
	localparam logic [2:0] CCMS_RESET_CODE = CCMS_CODE_X4;

	// ------------------------------------------------------------------
	// Multiplication factors, held in halves so 1.5 and 2.5 stay integral
	// ------------------------------------------------------------------
	localparam logic [3:0] CCMS_F2_X4 = 4'h8;
	localparam logic [3:0] CCMS_F2_X3 = 4'h6;
	localparam logic [3:0] CCMS_F2_X2 = 4'h4;
	localparam logic [3:0] CCMS_F2_X5 = 4'hA;
	localparam logic [3:0] CCMS_F2_X1P5 = 4'h3;
	localparam logic [3:0] CCMS_F2_X2P5 = 4'h5;
	localparam logic [3:0] CCMS_F2_NONE = 4'h0;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CCMS_CLK_PERIOD_NS = 20;
	localparam int CCMS_OSC_PERIOD_INIT_NS = 400;
	localparam logic [15:0] CCMS_OSC_PERIOD_INIT_CYC =
		16'(CCMS_OSC_PERIOD_INIT_NS / CCMS_CLK_PERIOD_NS);
	localparam logic [15:0] CCMS_PERIOD_MIN_CYC = 16'h000A;
	localparam logic [1:0] CCMS_RESYNC_RISES = 2'h2;

	typedef enum logic [1:0]
	{
		CCMS_SRC_PLL = 2'h0,
		CCMS_SRC_DIRECT = 2'h1,
		CCMS_SRC_PRESCALE = 2'h2
	} ccms_src_t;

	typedef enum logic
	{
		CCMS_ST_CAPTURE = 1'b0,
		CCMS_ST_RUN = 1'b1
	} ccms_state_t;

	typedef struct packed
	{
		logic [2:0] code;
		ccms_src_t src;
		logic [3:0] factor2;
	} ccms_cfg_t;

	localparam ccms_cfg_t CCMS_RESET_CFG = '{code: CCMS_RESET_CODE, src: CCMS_SRC_PLL,
		factor2: CCMS_F2_X4};

	typedef struct packed
	{
		logic level;
		logic rise;
		logic fall;
	} ccms_core_t;

	function automatic ccms_cfg_t ccms_decode(input logic [2:0] code);
		ccms_cfg_t cfg;
		cfg.code = code;
		cfg.src = CCMS_SRC_PLL;
		case (code)
			CCMS_CODE_X4: cfg.factor2 = CCMS_F2_X4;
			CCMS_CODE_X3: cfg.factor2 = CCMS_F2_X3;
			CCMS_CODE_X2: cfg.factor2 = CCMS_F2_X2;
			CCMS_CODE_X5: cfg.factor2 = CCMS_F2_X5;
			CCMS_CODE_X1P5: cfg.factor2 = CCMS_F2_X1P5;
			CCMS_CODE_X2P5: cfg.factor2 = CCMS_F2_X2P5;
			CCMS_CODE_DIRECT:
			begin
				cfg.src = CCMS_SRC_DIRECT;
				cfg.factor2 = CCMS_F2_NONE;
			end
			default:
			begin
				cfg.src = CCMS_SRC_PRESCALE;
				cfg.factor2 = CCMS_F2_NONE;
			end
		endcase
		return cfg;
	endfunction : ccms_decode

endpackage : ccms_pkg

/* hdl/ccms_clock_mode_select.sv */
// Core clock mode selector: picks prescaler, direct drive or multiplier.
// Assumes the oscillator input and the mode pins are synchronous to clk,
// and that clk is well above the fastest core clock to be modelled.
`timescale 1ns/1ps

module ccms_clock_mode_select
	import ccms_pkg::*;
#(
	parameter int PERIOD_W = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Configuration pins and oscillator
	input wire logic [2:0] clock_mode_pins,
	input wire logic oscillator_input_clock,
	// Core clock and its edge strobes
	output ccms_core_t core_clock,
	// Captured configuration
	output ccms_cfg_t mode_cfg,
	output logic mode_valid
);

	// ------------------------------------------------------------------
	// Mode capture
	// ------------------------------------------------------------------
	ccms_state_t state;
	ccms_state_t next_state;

	always_comb
	begin
		case (state)
			CCMS_ST_CAPTURE: next_state = CCMS_ST_RUN;
			CCMS_ST_RUN: next_state = CCMS_ST_RUN;
			default: next_state = CCMS_ST_CAPTURE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			state <= CCMS_ST_CAPTURE;
		else
			state <= next_state;
	end

	// Async reset may only load a constant, so the pins are caught on
	// the first edge after release; the strap must still be valid then.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			mode_cfg <= CCMS_RESET_CFG;
		else if (state == CCMS_ST_CAPTURE)
			mode_cfg <= ccms_decode(clock_mode_pins);
	end
	// Never reloaded in run state, whatever the pins do later

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			mode_valid <= 1'b0;
		else
			mode_valid <= (state == CCMS_ST_RUN);
	end

	// ------------------------------------------------------------------
	// Oscillator edge detection
	// ------------------------------------------------------------------
	logic osc_prev;
	logic osc_rise;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			osc_prev <= 1'b0;
		else
			osc_prev <= oscillator_input_clock;
	end

	// Previous level is forced low in reset; the run state term masks any edge before run state
	assign osc_rise = oscillator_input_clock & ~osc_prev & (state == CCMS_ST_RUN);

	// ------------------------------------------------------------------
	// Input period tracking for the multiplier
	// ------------------------------------------------------------------
	// Resync spans two input periods so that the half-integer factors
	// still land on a whole number of core periods at each correction.
	logic [1:0] rise_cnt;
	logic [PERIOD_W-1:0] span_cnt;
	logic [PERIOD_W-1:0] per_est;
	logic resync;
	logic [PERIOD_W-1:0] span_half;
	logic signed [PERIOD_W:0] per_diff;
	logic signed [PERIOD_W:0] per_step;
	logic [PERIOD_W-1:0] next_per_est;
	logic span_valid;

	assign resync = osc_rise && (rise_cnt == CCMS_RESYNC_RISES - 2'h1);
	assign span_half = span_cnt >> 1;
	assign per_diff = $signed({1'b0, span_half}) - $signed({1'b0, per_est});

	always_comb
	begin
		// Move only half way to the new measurement: no abrupt step.
		// A last unit of error still moves, else truncation stalls lock.
		per_step = per_diff >>> 1;
		if (per_step == '0)
			per_step = per_diff;
		next_per_est = PERIOD_W'($signed({1'b0, per_est}) + per_step);
		if (next_per_est < PERIOD_W'(CCMS_PERIOD_MIN_CYC))
			next_per_est = PERIOD_W'(CCMS_PERIOD_MIN_CYC);
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rise_cnt <= 2'h0;
		else if (resync)
			rise_cnt <= 2'h0;
		else if (osc_rise)
			rise_cnt <= rise_cnt + 2'h1;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			span_cnt <= '0;
		else if (resync)
			span_cnt <= PERIOD_W'(1);
		else if (span_cnt != '1)
			span_cnt <= span_cnt + PERIOD_W'(1);
	end

	// First span runs from release, not from a rise, so it is discarded
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			span_valid <= 1'b0;
		else if (resync)
			span_valid <= 1'b1;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			per_est <= PERIOD_W'(CCMS_OSC_PERIOD_INIT_CYC);
		else if (resync && span_valid && span_cnt != '1)
			per_est <= next_per_est;
	end

	// ------------------------------------------------------------------
	// Multiplier phase accumulator
	// ------------------------------------------------------------------
	// Adding the half-factor every cycle and wrapping at one input period
	// gives factor2 toggles, that is factor full core periods, per period.
	logic [PERIOD_W:0] acc;
	logic [PERIOD_W:0] acc_sum;
	logic pll_toggle;

	assign acc_sum = acc + (PERIOD_W + 1)'(mode_cfg.factor2);
	assign pll_toggle = acc_sum >= {1'b0, per_est};

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			acc <= '0;
		else if (mode_cfg.src != CCMS_SRC_PLL || state != CCMS_ST_RUN)
			acc <= '0;
		else if (pll_toggle)
			acc <= acc_sum - {1'b0, per_est};
		else
			acc <= acc_sum;
	end

	// ------------------------------------------------------------------
	// Core clock source selection
	// ------------------------------------------------------------------
	logic next_level;

	always_comb
	begin
		next_level = core_clock.level;
		if (state == CCMS_ST_RUN)
		begin
			case (mode_cfg.src)
				CCMS_SRC_DIRECT:
					next_level = oscillator_input_clock;
				CCMS_SRC_PRESCALE:
				begin
					// One phase per full input period
					if (osc_rise)
						next_level = ~core_clock.level;
				end
				CCMS_SRC_PLL:
				begin
					if (pll_toggle)
						next_level = ~core_clock.level;
				end
				default: next_level = core_clock.level;
			endcase
		end
	end

	// Edge strobes are registered with the level so a consumer can act
	// on either phase boundary in the same cycle the level changes.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			core_clock <= '0;
		end
		else
		begin
			core_clock.level <= next_level;
			core_clock.rise <= next_level & ~core_clock.level;
			core_clock.fall <= ~next_level & core_clock.level;
		end
	end

endmodule : ccms_clock_mode_select

/* tb/ccms_osc_model.sv */
// Oscillator source model: free-running clock, phases counted in clk cycles.
// Assumes hi_cyc and lo_cyc are at least 1 and change only between frames.
`timescale 1ns/1ps
module ccms_osc_model
(
	// Reference
	input wire logic clk,
	// Phase lengths
	input wire logic [7:0] hi_cyc,
	input wire logic [7:0] lo_cyc,
	// Oscillator
	output logic osc
);
	logic [7:0] cnt = 8'h00;
	logic level = 1'b0;
	assign osc = level;
	// Falling edge, so the block samples a settled level
	always @(negedge clk)
	begin
		if (cnt + 8'h01 >= (level ? hi_cyc : lo_cyc))
		begin
			cnt <= 8'h00;
			level <= !level;
		end
		else
			cnt <= cnt + 8'h01;
	end
endmodule : ccms_osc_model

/* tb/ccms_checker.sv */
// Checker for the core clock mode selector, bound to its top module.
// Assumes an oscillator period near 20 clk cycles in multiplier mode.
`timescale 1ns/1ps
module ccms_checker
	import ccms_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Watched ports
	input wire logic [2:0] clock_mode_pins,
	input wire logic oscillator_input_clock,
	input ccms_core_t core_clock,
	input ccms_cfg_t mode_cfg,
	input wire logic mode_valid
);
	localparam logic [3:0] F2 [8] = '{4'h5, 4'h0, 4'h3, 4'h0, 4'hA, 4'h4, 4'h6, 4'h8};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_capture;
		$rose(mode_valid) |-> mode_cfg.code == $past(clock_mode_pins, 2);
	endproperty
	a_capture: assert property (p_capture) else $error("strap lost");
	property p_hold;
		mode_valid |=> mode_valid && $stable(mode_cfg);
	endproperty
	a_hold: assert property (p_hold) else $error("mode moved");
	property p_decode;
		mode_valid |-> mode_cfg.factor2 == F2[mode_cfg.code] && mode_cfg.src == (mode_cfg.code
			== 3'h3 ? CCMS_SRC_DIRECT : mode_cfg.code == 3'h1 ? CCMS_SRC_PRESCALE : CCMS_SRC_PLL);
	endproperty
	a_decode: assert property (p_decode) else $error("bad decode");
	property p_direct;
		mode_valid && $past(mode_valid) && mode_cfg.src == CCMS_SRC_DIRECT
			|-> core_clock.level == $past(oscillator_input_clock);
	endproperty
	a_direct: assert property (p_direct) else $error("direct lag");
	property p_presc;
		mode_valid && $past(mode_valid, 3) && mode_cfg.src == CCMS_SRC_PRESCALE
			|-> $changed(core_clock.level) == ($past(oscillator_input_clock)
			&& !$past(oscillator_input_clock, 2));
	endproperty
	a_presc: assert property (p_presc) else $error("prescale phase");
	property p_rise;
		mode_valid |-> core_clock.rise == $rose(core_clock.level);
	endproperty
	a_rise: assert property (p_rise) else $error("rise strobe");
	property p_fall;
		mode_valid |-> core_clock.fall == $fell(core_clock.level);
	endproperty
	a_fall: assert property (p_fall) else $error("fall strobe");
	property p_pll;
		mode_valid && mode_cfg.src == CCMS_SRC_PLL && $changed(core_clock.level)
			|=> $stable(core_clock.level) ##[0:7] $changed(core_clock.level);
	endproperty
	a_pll: assert property (p_pll) else $error("multiplier phase");
endmodule : ccms_checker

bind ccms_clock_mode_select ccms_checker i_ccms_checker (.clk, .rst_b, .clock_mode_pins,
	.oscillator_input_clock, .core_clock, .mode_cfg, .mode_valid);

/* tb/test_cpu_clock_mode_select.sv */
// Bench for the core clock mode selector: straps each mode, counts core edges.
// Assumes the oscillator model and the checker are compiled before it.
`timescale 1ns/1ps
module test_cpu_clock_mode_select;
	import ccms_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] pins = 3'h7;
	logic [7:0] hi = 8'h0A;
	logic [7:0] lo = 8'h0A;
	logic osc;
	ccms_core_t core;
	ccms_cfg_t cfg;
	logic valid;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	ccms_osc_model i_ccms_osc_model (.clk(clk), .hi_cyc(hi), .lo_cyc(lo), .osc(osc));
	ccms_clock_mode_select i_ccms_clock_mode_select (.clk(clk), .rst_b(rst_b),
		.clock_mode_pins(pins), .oscillator_input_clock(osc), .core_clock(core),
		.mode_cfg(cfg), .mode_valid(valid));
	initial forever #10 clk = !clk;
	task automatic check(input logic [15:0] got, input logic [15:0] lo_v, input logic [15:0] hi_v);
		check_count++;
		if ((^got === 1'bx) || got < lo_v || got > hi_v)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo_v, hi_v);
		end
	endtask : check
	// Strap, then scramble the pins once the capture edge has passed
	task automatic strap(input logic [2:0] code);
		rst_b = 1'b0;
		pins = code;
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		pins = ~code;
		repeat (4) @(negedge clk);
		check(16'({valid, cfg.code}), 16'({1'b1, code}), 16'({1'b1, code}));
	endtask : strap
	task automatic rises(input int periods, output int n);
		n = 0;
		@(posedge osc);
		repeat (periods * (hi + lo)) @(negedge clk) n += int'(core.rise);
	endtask : rises
	task automatic high_time(output int n);
		n = 0;
		@(posedge core.level);
		@(negedge clk);
		while (core.level === 1'b1)
		begin
			n++;
			@(negedge clk);
		end
	endtask : high_time
	task automatic t_pll;
		logic [2:0] codes [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0};
		int f2 [6] = '{8, 6, 4, 10, 3, 5};
		int n;
		foreach (codes[i])
		begin
			strap(codes[i]);
			rises(10, n);
			check(16'(n), 16'(f2[i] * 5 - 1), 16'(f2[i] * 5 + 1));
		end
	endtask : t_pll
	// Slower oscillator: the multiplier must pull in without losing lock
	task automatic t_resync;
		int n;
		strap(3'h7);
		hi = 8'h0C;
		lo = 8'h0C;
		repeat (20) @(posedge osc);
		rises(10, n);
		check(16'(n), 16'h0027, 16'h0029);
	endtask : t_resync
	// Uneven duty: direct follows it, prescaler still gives whole periods
	task automatic t_direct_presc;
		int n;
		hi = 8'h06;
		lo = 8'h0E;
		strap(3'h3);
		rises(10, n);
		check(16'(n), 16'h000A, 16'h000A);
		high_time(n);
		check(16'(n), 16'h0006, 16'h0006);
		strap(3'h1);
		rises(10, n);
		check(16'(n), 16'h0005, 16'h0005);
		high_time(n);
		check(16'(n), 16'h0014, 16'h0014);
	endtask : t_direct_presc
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			mismatches++;
			conclude();
		end
	end
	initial
	begin
		repeat (16) @(negedge clk);
		t_pll();
		t_resync();
		t_direct_presc();
		conclude();
	end
endmodule : test_cpu_clock_mode_select
